// File: src/vic_pkg.sv
// Constants, field positions and types of the vectored interrupt control block
package vic_pkg;
   // Register indices, byte address is four times the index
   localparam logic [7:0]  MISC_IDX       = 8'h0a;
   localparam logic [7:0]  EVT_IDX        = 8'h10;
   localparam logic [7:0]  EMASK_IDX      = 8'h11;
   localparam logic [7:0]  PEND_IDX       = 8'h12;
   localparam logic [7:0]  MISC_ADDR      = MISC_IDX << 2;
   localparam logic [7:0]  EVT_ADDR       = EVT_IDX << 2;
   localparam logic [7:0]  EMASK_ADDR     = EMASK_IDX << 2;
   localparam logic [7:0]  PEND_ADDR      = PEND_IDX << 2;
   // Field positions
   localparam int          FLAG_BIT       = 7;
   localparam int          MASK_BIT       = 6;
   localparam int          CC_I_BIT       = 3;
   localparam int          EVT_TAKEN      = 0;
   localparam int          EVT_EDGE       = 1;
   localparam int          EVT_RETURN     = 2;
   localparam int          EVT_W          = 3;
   // Reset values
   localparam logic [7:0]  MISC_RESET     = 8'h40;
   localparam logic [2:0]  EMASK_RESET    = 3'h0;
   // Sequence lengths in bytes
   localparam logic [3:0]  FULL_PUSH      = 4'h5;
   localparam logic [3:0]  CALL_PUSH      = 4'h2;
   localparam logic [3:0]  PULL_BYTES     = 4'h5;
   // Vector table bases and top slot
   localparam logic [15:0] VEC_BASE_4K    = 16'h0ff0;
   localparam logic [15:0] VEC_BASE_8K    = 16'h1ff0;
   localparam logic [3:0]  VEC_TOP        = 4'he;
   // Bus answers
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Sources in priority order, index 0 highest
   typedef enum logic [2:0] {
      SRC_RESET    = 3'b000,
      SRC_SOFT     = 3'b001,
      SRC_LINE1    = 3'b010,
      SRC_SHARED   = 3'b011,
      SRC_CAPTURE  = 3'b100,
      SRC_COMPARE  = 3'b101,
      SRC_OVERFLOW = 3'b110,
      SRC_NONE     = 3'b111
   } src_type;

   // Entry and return sequencer
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_PUSH    = 3'b001,
      ST_VEC     = 3'b010,
      ST_PULL    = 3'b011,
      ST_RESTORE = 3'b100
   } seq_type;
endpackage : vic_pkg

// File: src/fall_edge_detect.sv
// Falling edge detector for an active-low request line
`timescale 1ns/1ps
module fall_edge_detect #(
   parameter int W = 1
) (
   // Clock and reset
   input  logic         aclk,
   input  logic         aresetn,
   // Line and detected edge
   input  logic [W-1:0] level_n,
   output logic [W-1:0] fall
);
   typedef struct packed {
      logic [W-1:0] prev;
      logic [W-1:0] fall;
   } det_type;

   det_type s_r;
   det_type s_nxt;

   // Edge is old high and new low; idle line assumed high
   always_comb
   begin
      s_nxt.prev = level_n;
      s_nxt.fall = s_r.prev & ~level_n;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_r <= '{prev: {W{1'b1}}, fall: {W{1'b0}}};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign fall = s_r.fall;
endmodule : fall_edge_detect

// File: src/vectored_interrupt_control.sv
// Vectored interrupt arbitration, stacking sequencer and register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module vectored_interrupt_control (
   // Clock and reset
   input  logic                  aclk,
   input  logic                  aresetn,
   // Register bus, write side
   input  logic [7:0]            awaddr,
   input  logic                  awvalid,
   output logic                  awready,
   input  logic [31:0]           wdata,
   input  logic [3:0]            wstrb,
   input  logic                  wvalid,
   output logic                  wready,
   output logic [1:0]            bresp,
   output logic                  bvalid,
   input  logic                  bready,
   // Register bus, read side
   input  logic [7:0]            araddr,
   input  logic                  arvalid,
   output logic                  arready,
   output logic [31:0]           rdata,
   output logic [1:0]            rresp,
   output logic                  rvalid,
   input  logic                  rready,
   // Event interrupt
   output logic                  irq,
   // CPU core side
   input  logic                  boundary,
   input  logic                  soft_trap_instr,
   input  logic                  call_exec,
   input  logic                  return_from_trap_instr,
   input  logic [15:0]           cpu_pc,
   input  logic [7:0]            cpu_acc,
   input  logic [7:0]            cpu_idx,
   input  logic [7:0]            condition_code_reg,
   input  logic                  mem_8k,
   output logic                  busy,
   output logic                  stack_push,
   output logic [7:0]            stack_wdata,
   output logic                  stack_pop,
   input  logic [7:0]            stack_rdata,
   output logic                  vec_valid,
   output logic [15:0]           vec_addr,
   output logic [7:0]            new_cc,
   output logic                  restore_valid,
   output logic [15:0]           restore_pc,
   output logic [7:0]            restore_acc,
   output logic [7:0]            restore_idx,
   output logic [7:0]            restore_cc,
   // Interrupt sources
   input  logic                  ext_irq_line_one_n,
   input  logic                  ext_irq_line_two_n,
   input  logic                  timer1_req,
   input  logic                  capture_flag,
   input  logic                  compare_flag,
   input  logic                  overflow_flag,
   input  logic                  capture_inh,
   input  logic                  compare_inh,
   input  logic                  overflow_inh
);
   import vic_pkg::*;

   typedef struct packed {
      seq_type           st;
      logic [3:0]        cnt;
      src_type           src;
      logic              do_call;
      logic [15:0]       pc;
      logic [7:0]        acc;
      logic [7:0]        idx;
      logic [7:0]        cc;
      logic              rst_pend;
      logic [7:0]        misc;
      logic [EVT_W-1:0]  evt;
      logic [EVT_W-1:0]  emask;
      logic              push;
      logic [7:0]        push_data;
      logic              pop;
      logic              vec_valid;
      logic [15:0]       vec_addr;
      logic [7:0]        new_cc;
      logic              restore_valid;
      logic              busy;
      logic              irq;
      logic              aw_got;
      logic              w_got;
      logic [7:0]        waddr;
      logic [7:0]        wbyte;
      logic              wlane;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } state_type;

   state_type        s_r;
   state_type        s_nxt;
   logic             line2_fall;
   logic [6:0]       req;
   logic [6:0]       gated;
   logic             i_mask;
   src_type          pick;
   logic [EVT_W-1:0] evt_set;

   ////////////////////////////////////////////////////////////////////////
   // Request gathering

   fall_edge_detect #(
      .W       (1)
   ) u_line2_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .level_n (ext_irq_line_two_n),
      .fall    (line2_fall)
   );

   // One bit per source, index equals priority order
   assign i_mask          = condition_code_reg[CC_I_BIT];
   assign req[SRC_RESET]  = s_r.rst_pend;
   assign req[SRC_SOFT]   = soft_trap_instr;
   assign req[SRC_LINE1]  = ~ext_irq_line_one_n;
   // Shared slot: timer one or unmasked line-two flag
   assign req[SRC_SHARED] = timer1_req
                          | (s_r.misc[FLAG_BIT] & ~s_r.misc[MASK_BIT]);
   // Flag stays set while the inhibit is up, so clearing it raises the request
   assign req[SRC_CAPTURE]  = capture_flag & ~capture_inh;
   assign req[SRC_COMPARE]  = compare_flag & ~compare_inh;
   assign req[SRC_OVERFLOW] = overflow_flag & ~overflow_inh;
   // Global mask gates every maskable source alike
   assign gated = {req[6:2] & {5{~i_mask}}, req[1:0]};

   // Lowest index wins, the others simply stay pending
   always_comb
   begin
      pick = SRC_NONE;
      for (int i = 6; i >= 0; i--)
      begin
         if (gated[i])
         begin
            pick = src_type'(i[2:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.push = 1'b0;
      s_nxt.pop = 1'b0;
      s_nxt.vec_valid = 1'b0;
      s_nxt.restore_valid = 1'b0;
      evt_set = '0;
      evt_set[EVT_EDGE] = line2_fall;

      // Sequencer
      case (s_r.st)
         ST_IDLE:
         begin
            // Reset vector needs no boundary and pushes nothing
            if (s_r.rst_pend)
            begin
               s_nxt.src = SRC_RESET;
               s_nxt.cc = '0;
               s_nxt.rst_pend = 1'b0;
               s_nxt.st = ST_VEC;
            end
            else if (boundary && pick != SRC_NONE)
            begin
               s_nxt.src = pick;
               s_nxt.do_call = 1'b0;
               s_nxt.pc = cpu_pc;
               s_nxt.acc = cpu_acc;
               s_nxt.idx = cpu_idx;
               s_nxt.cc = condition_code_reg;
               s_nxt.cnt = '0;
               s_nxt.st = ST_PUSH;
            end
            else if (boundary && return_from_trap_instr)
            begin
               s_nxt.cnt = '0;
               s_nxt.st = ST_PULL;
            end
            else if (boundary && call_exec)
            begin
               s_nxt.do_call = 1'b1;
               s_nxt.pc = cpu_pc;
               s_nxt.cnt = '0;
               s_nxt.st = ST_PUSH;
            end
         end
         ST_PUSH:
         begin
            // Order: pc low, pc high, index, accumulator, condition codes
            s_nxt.push = 1'b1;
            case (s_r.cnt)
               4'h0:    s_nxt.push_data = s_r.pc[7:0];
               4'h1:    s_nxt.push_data = s_r.pc[15:8];
               4'h2:    s_nxt.push_data = s_r.idx;
               4'h3:    s_nxt.push_data = s_r.acc;
               default: s_nxt.push_data = s_r.cc;
            endcase
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.do_call && s_r.cnt == CALL_PUSH - 4'h1)
            begin
               s_nxt.st = ST_IDLE;
            end
            else if (s_r.cnt == FULL_PUSH - 4'h1)
            begin
               s_nxt.st = ST_VEC;
            end
         end
         ST_VEC:
         begin
            // Slot pairs run downward from the top, two bytes per source
            s_nxt.vec_valid = 1'b1;
            s_nxt.vec_addr = {(mem_8k ? VEC_BASE_8K[15:4] : VEC_BASE_4K[15:4]),
                              VEC_TOP - {s_r.src, 1'b0}};
            s_nxt.new_cc = s_r.cc;
            s_nxt.new_cc[CC_I_BIT] = 1'b1;
            evt_set[EVT_TAKEN] = 1'b1;
            s_nxt.st = ST_IDLE;
         end
         ST_PULL:
         begin
            // Read data is valid while the pop strobe is high
            if (s_r.pop)
            begin
               case (s_r.cnt)
                  4'h0:    s_nxt.cc = stack_rdata;
                  4'h1:    s_nxt.acc = stack_rdata;
                  4'h2:    s_nxt.idx = stack_rdata;
                  4'h3:    s_nxt.pc[15:8] = stack_rdata;
                  default: s_nxt.pc[7:0] = stack_rdata;
               endcase
               s_nxt.cnt = s_r.cnt + 4'h1;
               if (s_r.cnt == PULL_BYTES - 4'h1)
               begin
                  s_nxt.st = ST_RESTORE;
               end
            end
            else
            begin
               s_nxt.pop = 1'b1;
            end
         end
         ST_RESTORE:
         begin
            s_nxt.restore_valid = 1'b1;
            evt_set[EVT_RETURN] = 1'b1;
            s_nxt.st = ST_IDLE;
         end
         default:
         begin
            s_nxt.st = ST_IDLE;
         end
      endcase
      s_nxt.busy = (s_nxt.st != ST_IDLE);

      // Bus write: address and data may come in either order
      if (awvalid && s_r.awready)
      begin
         s_nxt.aw_got = 1'b1;
         s_nxt.waddr = awaddr;
      end
      if (wvalid && s_r.wready)
      begin
         s_nxt.w_got = 1'b1;
         s_nxt.wbyte = wdata[7:0];
         s_nxt.wlane = wstrb[0];
      end
      if (bready && s_r.bvalid)
      begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
      begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         case (s_r.waddr)
            MISC_ADDR:
            begin
               if (s_r.wlane)
               begin
                  // Writing zero clears the flag, writing one leaves it
                  s_nxt.misc[FLAG_BIT] = s_r.misc[FLAG_BIT] & s_r.wbyte[FLAG_BIT];
                  s_nxt.misc[MASK_BIT] = s_r.wbyte[MASK_BIT];
               end
            end
            EVT_ADDR:
            begin
               if (s_r.wlane)
               begin
                  s_nxt.evt = s_r.evt & ~s_r.wbyte[EVT_W-1:0];
               end
            end
            EMASK_ADDR:
            begin
               if (s_r.wlane)
               begin
                  s_nxt.emask = s_r.wbyte[EVT_W-1:0];
               end
            end
            PEND_ADDR:
            begin
               s_nxt.bresp = RESP_OKAY;
            end
            default:
            begin
               s_nxt.bresp = RESP_SLVERR;
            end
         endcase
      end
      // Hardware sets win over a same-cycle software clear
      s_nxt.misc[FLAG_BIT] = s_nxt.misc[FLAG_BIT] | line2_fall;
      s_nxt.evt = s_nxt.evt | evt_set;
      s_nxt.irq = |(s_nxt.evt & s_nxt.emask);
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

      // Bus read: one outstanding, answer one cycle after the address
      if (rready && s_r.rvalid)
      begin
         s_nxt.rvalid = 1'b0;
      end
      if (arvalid && s_r.arready)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         s_nxt.rdata = '0;
         case (araddr)
            MISC_ADDR:  s_nxt.rdata[7:0] = s_r.misc;
            EVT_ADDR:   s_nxt.rdata[EVT_W-1:0] = s_r.evt;
            EMASK_ADDR: s_nxt.rdata[EVT_W-1:0] = s_r.emask;
            PEND_ADDR:  s_nxt.rdata[10:0] = {s_r.st, 1'b0, req};
            default:    s_nxt.rresp = RESP_SLVERR;
         endcase
      end
      s_nxt.arready = !s_nxt.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   // Reset leaves line two disabled and the reset vector pending
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_r <= '0;
         s_r.rst_pend <= 1'b1;
         s_r.misc <= MISC_RESET;
         s_r.emask <= EMASK_RESET;
         s_r.src <= SRC_NONE;
         s_r.busy <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign awready       = s_r.awready;
   assign wready        = s_r.wready;
   assign bvalid        = s_r.bvalid;
   assign bresp         = s_r.bresp;
   assign arready       = s_r.arready;
   assign rvalid        = s_r.rvalid;
   assign rdata         = s_r.rdata;
   assign rresp         = s_r.rresp;
   assign irq           = s_r.irq;
   assign busy          = s_r.busy;
   assign stack_push    = s_r.push;
   assign stack_wdata   = s_r.push_data;
   assign stack_pop     = s_r.pop;
   assign vec_valid     = s_r.vec_valid;
   assign vec_addr      = s_r.vec_addr;
   assign new_cc        = s_r.new_cc;
   assign restore_valid = s_r.restore_valid;
   assign restore_pc    = s_r.pc;
   assign restore_acc   = s_r.acc;
   assign restore_idx   = s_r.idx;
   assign restore_cc    = s_r.cc;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   AST_FLAG_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
      line2_fall |=> s_r.misc[FLAG_BIT])
      else $error("line-two edge did not set the flag");

   AST_NO_SW_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_r.misc[FLAG_BIT]) |-> $past(line2_fall))
      else $error("line-two flag rose without an edge");

   AST_MASKED_LINE2: assert property (@(posedge aclk) disable iff (!aresetn)
      ($rose(s_r.st == ST_PUSH) && s_r.src == SRC_SHARED && !s_r.do_call)
      |-> $past(timer1_req || !s_r.misc[MASK_BIT]))
      else $error("masked line two was taken");

   AST_GLOBAL_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
      ($rose(s_r.st == ST_PUSH) && !s_r.do_call && s_r.src > SRC_SOFT)
      |-> !s_r.cc[CC_I_BIT])
      else $error("maskable source taken with global mask set");

   AST_RESET_VALUE: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) |-> (s_r.misc == MISC_RESET && s_r.st == ST_IDLE))
      else $error("line-two control not at reset value");

   AST_FULL_PUSH: assert property (@(posedge aclk) disable iff (!aresetn)
      ($rose(s_r.st == ST_PUSH) && !s_r.do_call)
      |-> ##1 s_r.push [*5] ##1 (s_r.vec_valid && !s_r.push))
      else $error("interrupt entry did not push five bytes");

   AST_CALL_PUSH: assert property (@(posedge aclk) disable iff (!aresetn)
      ($rose(s_r.st == ST_PUSH) && s_r.do_call)
      |-> ##1 s_r.push [*2] ##1 (!s_r.push && !s_r.vec_valid))
      else $error("call did not push exactly two bytes");

   AST_VECTOR: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.vec_valid |-> (s_r.new_cc[CC_I_BIT]
                         && s_r.vec_addr[3:0] == VEC_TOP - {s_r.src, 1'b0}
                         && s_r.vec_addr[15:4] == ($past(mem_8k) ? VEC_BASE_8K[15:4]
                                                                  : VEC_BASE_4K[15:4])))
      else $error("wrong vector or global mask left clear");

   AST_RETURN: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_r.st == ST_PULL) |-> ##11 (s_r.restore_valid && !s_r.busy))
      else $error("return did not restore in eleven cycles");

   AST_PRIORITY: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.st == ST_IDLE && !s_r.rst_pend && boundary && gated[SRC_LINE1]
       && !soft_trap_instr) |=> (s_r.st == ST_PUSH && s_r.src == SRC_LINE1))
      else $error("line one not taken ahead of lower sources");
endmodule : vectored_interrupt_control

// File: test/cpu_stack_model.sv
// Behavioural CPU stack on the far side of the block
`timescale 1ns/1ps
module cpu_stack_model (
   // Clock and reset
   input  logic       aclk,
   input  logic       aresetn,
   // Stack port of the block
   input  logic       stack_push,
   input  logic [7:0] stack_wdata,
   input  logic       stack_pop,
   output logic [7:0] stack_rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] sp;
   // Grows upward; a pop takes the top byte in its own cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sp <= 8'h00;
      else if (stack_push)
      begin
         mem[sp] <= stack_wdata;
         sp      <= sp + 8'h01;
      end
      else if (stack_pop)
         sp <= sp - 8'h01;
   end
   // Junk outside a pop, so a late sample shows up
   assign stack_rdata = stack_pop ? mem[sp - 8'h01] : ~mem[sp - 8'h01];
endmodule : cpu_stack_model

// File: test/vectored_interrupt_control_bench.sv
// Self-checking bench of the vectored interrupt control block
`timescale 1ns/1ps
module vectored_interrupt_control_bench;
   import vic_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic        bvalid, rvalid, irq, busy, boundary, mem_8k, vec_valid;
   logic        soft_trap_instr, call_exec, return_from_trap_instr, restore_valid;
   logic        stack_push, stack_pop, ext_irq_line_two_n;
   logic [7:0]  awaddr, araddr, cpu_acc, cpu_idx, condition_code_reg, new_cc, stack_wdata;
   logic [7:0]  stack_rdata, restore_acc, restore_idx, restore_cc;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [15:0] cpu_pc, vec_addr, restore_pc;
   logic [4:0]  src;
   logic [2:0]  inh;
   logic [3:0]  wstrb;
   int          err_count, checks, n;
   logic        arready;

   vectored_interrupt_control dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .irq, .boundary, .soft_trap_instr, .call_exec, .return_from_trap_instr, .cpu_pc,
      .cpu_acc, .cpu_idx, .condition_code_reg, .mem_8k, .busy, .stack_push, .stack_wdata,
      .stack_pop, .stack_rdata, .vec_valid, .vec_addr, .new_cc, .restore_valid, .restore_pc,
      .restore_acc, .restore_idx, .restore_cc, .ext_irq_line_one_n(~src[0]),
      .ext_irq_line_two_n, .timer1_req(src[1]), .capture_flag(src[2]), .compare_flag(src[3]),
      .overflow_flag(src[4]), .capture_inh(inh[0]), .compare_inh(inh[1]),
      .overflow_inh(inh[2]));
   cpu_stack_model stk (.aclk, .aresetn, .stack_push, .stack_wdata, .stack_pop, .stack_rdata);

   ////////////////////////////////////////////////////////////////////////////////
   // Shared comparison, verdict and wait limit
   task check(input string what, input logic [47:0] exp, input logic [47:0] got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task give_verdict;
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // A hung handshake ends the run as a failure
   task lim(input int k);
      if (k > 40)
      begin
         err_count++;
         give_verdict();
      end
   endtask : lim

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus master, address and data offered together
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      n = 0;
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      do
      begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         lim(n);
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      check("bresp", er, bresp);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      n = 0;
      {araddr, arvalid, rready} <= {a, 2'h3};
      do
      begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         lim(n);
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      check("rdata", {er, exp}, {rresp, rdata});
   endtask : rd
   // One instruction boundary of kind {return, call, soft trap}
   task go(input logic [2:0] k, input logic want, input logic [15:0] v);
      @(posedge aclk);
      n = 0;
      while (busy !== 1'b0)
      begin
         @(posedge aclk);
         n++;
         lim(n);
      end
      {boundary, return_from_trap_instr, call_exec, soft_trap_instr} <= {1'b1, k};
      @(posedge aclk);
      {boundary, return_from_trap_instr, call_exec, soft_trap_instr} <= 4'h0;
      n = 0;
      do
         @(posedge aclk);
      while (vec_valid !== 1'b1 && restore_valid !== 1'b1 && ++n < 16);
      check("vec_valid", want, vec_valid);
      if (want) check("vec_addr", v, vec_addr);
   endtask : go

   ////////////////////////////////////////////////////////////////////////////////
   // Free running 40 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // Main sequence
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, boundary, mem_8k} = 8'h0;
      {soft_trap_instr, call_exec, return_from_trap_instr, src, inh} = 11'h0;
      {awaddr, araddr, wdata, cpu_pc, cpu_acc, cpu_idx, condition_code_reg} = '0;
      {ext_irq_line_two_n, err_count, checks} = '0;
      ext_irq_line_two_n = 1'b1;
      wstrb = 4'h1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         lim(++n);
      end
      while (vec_valid !== 1'b1);
      check("reset vector", {16'h0ffe, 8'h08}, {vec_addr, new_cc});
      rd(MISC_ADDR, 32'h40, RESP_OKAY);
      // Soft trap ignores the mask bit; full state stacked, then returned
      {cpu_pc, cpu_acc, cpu_idx, condition_code_reg, mem_8k} <= {16'h1234, 8'h56, 8'h78,
         8'h08, 1'b1};
      go(3'b001, 1'b1, 16'h1ffc);
      check("stack", {8'h08, 40'h3412785608}, {new_cc, stk.mem[0], stk.mem[1], stk.mem[2],
         stk.mem[3], stk.mem[4]});
      go(3'b100, 1'b0, 16'h0);
      check("restore", 41'h1_1234_56_78_08, {restore_valid, restore_pc, restore_acc,
         restore_idx, restore_cc});
      cpu_pc <= 16'habcd;
      go(3'b010, 1'b0, 16'h0);
      check("call stack", 24'h02cdab, {stk.sp, stk.mem[0], stk.mem[1]});
      // All sources except line two at once, taken one by one; timer events held off by inhibits
      {condition_code_reg, mem_8k, src, inh} <= {9'h0, 5'h1f, 3'h7};
      for (int i = 0; i < 5; i++)
      begin
         // Inhibits drop only once the held-off timer events are shown to stay quiet
         if (i == 2)
         begin
            go(3'b000, 1'b0, 16'h0);
            inh <= 3'h0;
         end
         go(3'b000, 1'b1, 16'h0ffa - 16'(2 * i));
         src[i] <= 1'b0;
      end
      // Line two: edge, mask, global mask, shared slot, software clear
      ext_irq_line_two_n <= 1'b0;
      wr(EMASK_ADDR, 32'h2, RESP_OKAY);
      rd(MISC_ADDR, 32'hc0, RESP_OKAY);
      check("irq", 1'b1, irq);
      go(3'b000, 1'b0, 16'h0);
      wr(MISC_ADDR, 32'h80, RESP_OKAY);
      condition_code_reg <= 8'h08;
      go(3'b000, 1'b0, 16'h0);
      condition_code_reg <= 8'h00;
      go(3'b000, 1'b1, 16'h0ff8);
      rd(MISC_ADDR, 32'h80, RESP_OKAY);
      wr(MISC_ADDR, 32'h40, RESP_OKAY);
      wr(MISC_ADDR, 32'hc0, RESP_OKAY);
      rd(MISC_ADDR, 32'h40, RESP_OKAY);
      // A write without its byte lane must leave the mask set
      wstrb <= 4'h0;
      wr(MISC_ADDR, 32'h0, RESP_OKAY);
      wstrb <= 4'h1;
      rd(MISC_ADDR, 32'h40, RESP_OKAY);
      rd(EMASK_ADDR, 32'h2, RESP_OKAY);
      wr(EVT_ADDR, 32'h2, RESP_OKAY);
      check("irq", 1'b0, irq);
      rd(EVT_ADDR, 32'h5, RESP_OKAY);
      wr(8'h3c, 32'hff, RESP_SLVERR);
      rd(8'h3c, 32'h0, RESP_SLVERR);
      give_verdict();
   end
endmodule : vectored_interrupt_control_bench
